// *** aom_mapper.sv ***
// four-channel analog output code mapper with an AXI4-Lite register slave
// Functional notes
// - function number 00h leaves the channel's stored function unchanged
// - function number FFh switches the channel off
// - 01h: legacy bipolar, rated +-16384, accepted +-20480
// - 05h: legacy 0..10 V, rated 0..16384, up to 20480, no underrange
// - 06h: legacy 0..20 mA, rated 0..16384, up to 20480, no underrange
// - 07h: legacy -10..0 V, down to -20480, no overrange
// - 09h: two's complement bipolar, rated +-27648, up to 32511
// - two's complement bipolar and negative ranges accept down to -32512
// - 0Dh: two's complement 0..10 V, 0..27648, up to 32511
// - 0Eh: two's complement 0..20 mA, 0..27648, up to 32511
// - 0Fh: two's complement -10..0 V, down to -32512, no overrange
// - any code beyond the accepted limits drives converter code zero
// - every channel resets to function 09h
// - legacy high byte bit 0 is the overflow flag
// - legacy high byte bit 1 flags internal error; bit 2 reads zero
// - legacy magnitude in high bits 3..7 and low bits 0..6, low bit 7 sign
// - two's complement format takes the whole word as a signed value
// - parameter bit 6 enables sending four diagnostic bytes on error
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module aom_mapper (
	input  wire logic                            aclk,
	input  wire logic                            aresetn,
	input  wire logic                            ce,
	input  wire logic [aom_pkg::AOM_AW-1:0]      s_axi_awaddr,
	input  wire logic                            s_axi_awvalid,
	output logic                                 s_axi_awready,
	input  wire logic [31:0]                     s_axi_wdata,
	input  wire logic [3:0]                      s_axi_wstrb,
	input  wire logic                            s_axi_wvalid,
	output logic                                 s_axi_wready,
	output logic [1:0]                           s_axi_bresp,
	output logic                                 s_axi_bvalid,
	input  wire logic                            s_axi_bready,
	input  wire logic [aom_pkg::AOM_AW-1:0]      s_axi_araddr,
	input  wire logic                            s_axi_arvalid,
	output logic                                 s_axi_arready,
	output logic [31:0]                          s_axi_rdata,
	output logic [1:0]                           s_axi_rresp,
	output logic                                 s_axi_rvalid,
	input  wire logic                            s_axi_rready,
	output aom_pkg::aom_dac_s [aom_pkg::AOM_NCH-1:0] dac_o,
	output logic [aom_pkg::AOM_NCH-1:0]          channel_active_leds,
	output logic                                 error_summary_led,
	output logic                                 diag_valid,
	input  wire logic                            diag_ready,
	output logic [31:0]                          diag_data
);
	import aom_pkg::*;

	// register state
	logic [15:0]      out_r     [AOM_NCH], out_nxt  [AOM_NCH];
	logic [7:0]       func_r    [AOM_NCH], func_nxt [AOM_NCH];
	logic             diag_en_r, diag_en_nxt;
	logic             perr_r,    perr_nxt;

	// bus state
	logic             aw_hold_r, aw_hold_nxt;
	logic [7:0]       awaddr_r,  awaddr_nxt;
	logic             w_hold_r,  w_hold_nxt;
	logic [31:0]      wdata_r,   wdata_nxt;
	logic [3:0]       wstrb_r,   wstrb_nxt;
	logic             bvalid_r,  bvalid_nxt;
	logic [1:0]       bresp_r,   bresp_nxt;
	logic             rvalid_r,  rvalid_nxt;
	logic [31:0]      rdata_r,   rdata_nxt;
	logic [1:0]       rresp_r,   rresp_nxt;

	// converter and error state
	aom_dac_s [AOM_NCH-1:0] dac_r, dac_nxt;
	logic [AOM_NCH-1:0] rng_err_r, rng_err_nxt;
	logic [AOM_NCH-1:0] int_err_r, int_err_nxt;
	logic             err_sum_r, err_sum_nxt;
	logic             dpend_r,   dpend_nxt;
	logic [31:0]      diag_r,    diag_nxt;

	logic             do_wr;
	logic             wr_hit;
	logic             perr_set;
	logic [31:0]      status;
	logic             err_now;

	assign s_axi_awready = ce & ~aw_hold_r;
	assign s_axi_wready  = ce & ~w_hold_r;
	assign s_axi_arready = ce & ~rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign do_wr         = aw_hold_r & w_hold_r & ~bvalid_r;

	always_comb begin
		status = 32'h0000_0000;
		for (int i = 0; i < AOM_NCH; i++) begin
			status[i]     = dac_r[i].active;
			status[4 + i] = rng_err_r[i];
			status[8 + i] = int_err_r[i];
		end
		status[AOM_ST_PERR]  = perr_r;
		status[AOM_ST_DPEND] = dpend_r;
	end

	// read mux; legacy bit 2 always reads back as zero
	function automatic logic [32:0] rd_mux(input logic [7:0] a);
		logic [15:0] w;
		w = 16'h0000;
		rd_mux = {1'b0, 32'h0000_0000};
		unique case (a)
			AOM_OFS_OUT0, AOM_OFS_OUT1, AOM_OFS_OUT2, AOM_OFS_OUT3: begin
				w = out_r[a[3:2]];
				if (aom_range(func_r[a[3:2]]).legacy)
					w[AOM_LG_ZERO] = 1'b0;
				rd_mux = {1'b0, 16'h0000, w};
			end
			AOM_OFS_PARAM: rd_mux[AOM_DIAG_EN] = diag_en_r;
			AOM_OFS_FUNC: rd_mux = {1'b0, func_r[3], func_r[2], func_r[1], func_r[0]};
			AOM_OFS_STAT: rd_mux = {1'b0, status};
			AOM_OFS_DIAG: rd_mux = {1'b0, diag_r};
			default:      rd_mux = {1'b1, 32'h0000_0000};
		endcase
	endfunction

	// bus and register next values
	always_comb begin
		logic [32:0] rd;
		logic [7:0]  b;
		rd          = rd_mux(s_axi_araddr);
		b           = 8'h00;
		aw_hold_nxt = aw_hold_r;
		awaddr_nxt  = awaddr_r;
		w_hold_nxt  = w_hold_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		rvalid_nxt  = rvalid_r;
		rdata_nxt   = rdata_r;
		rresp_nxt   = rresp_r;
		diag_en_nxt = diag_en_r;
		perr_set    = 1'b0;
		wr_hit      = 1'b0;
		for (int i = 0; i < AOM_NCH; i++) begin
			out_nxt[i]  = out_r[i];
			func_nxt[i] = func_r[i];
		end
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_nxt = 1'b1;
			wdata_nxt  = s_axi_wdata;
			wstrb_nxt  = s_axi_wstrb;
		end
		if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
		if (do_wr) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			wr_hit      = 1'b1;
			unique case (awaddr_r)
				AOM_OFS_OUT0, AOM_OFS_OUT1, AOM_OFS_OUT2, AOM_OFS_OUT3: begin
					for (int k = 0; k < 2; k++)
						if (wstrb_r[k])
							out_nxt[awaddr_r[3:2]][8*k +: 8] = wdata_r[8*k +: 8];
				end
				AOM_OFS_PARAM: begin
					if (wstrb_r[0])
						diag_en_nxt = wdata_r[AOM_DIAG_EN];
				end
				AOM_OFS_FUNC: begin
					for (int i = 0; i < AOM_NCH; i++) begin
						b = wdata_r[8*i +: 8];
						if (!wstrb_r[i] || b == AOM_FN_KEEP)
							func_nxt[i] = func_r[i];
						else if (b == AOM_FN_OFF)
							func_nxt[i] = AOM_FN_OFF;
						else if (!aom_range(b).bad)
							func_nxt[i] = b;
						else
							perr_set = 1'b1;
					end
				end
				AOM_OFS_STAT, AOM_OFS_DIAG: ;
				default: wr_hit = 1'b0;
			endcase
			bresp_nxt = wr_hit ? AOM_RESP_OKAY : AOM_RESP_SLVERR;
		end
		if (rvalid_r && s_axi_rready)
			rvalid_nxt = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = rd[31:0];
			rresp_nxt  = rd[32] ? AOM_RESP_SLVERR : AOM_RESP_OKAY;
		end
	end

	// sticky parameter error: write 1 to the status bit clears, a new error wins
	always_comb begin
		perr_nxt = perr_r;
		if (do_wr && awaddr_r == AOM_OFS_STAT && wstrb_r[2] && wdata_r[AOM_ST_PERR])
			perr_nxt = 1'b0;
		if (perr_set)
			perr_nxt = 1'b1;
	end

	// code mapping per channel
	always_comb begin
		aom_range_s         rg;
		logic [11:0]        mag;
		logic signed [16:0] m17;
		logic signed [16:0] v;
		logic               ovf;
		logic               ierr;
		logic               inr;
		rg   = aom_range(AOM_FN_RESET);
		mag  = 12'h000;
		m17  = AOM_ZERO;
		v    = AOM_ZERO;
		ovf  = 1'b0;
		ierr = 1'b0;
		inr  = 1'b0;
		for (int i = 0; i < AOM_NCH; i++) begin
			rg = aom_range(func_r[i]);
			if (rg.legacy) begin
				mag  = {out_r[i][15:11], out_r[i][6:0]};
				m17  = signed'({2'b00, mag, 3'b000});
				v    = out_r[i][AOM_LG_SIGN] ? -m17 : m17;
				ovf  = out_r[i][AOM_LG_OVF];
				ierr = out_r[i][AOM_LG_ERR];
			end else begin
				v    = signed'({out_r[i][15], out_r[i]});
				ovf  = 1'b0;
				ierr = 1'b0;
			end
			inr = (v >= rg.lo) && (v <= rg.hi) && !ovf;
			dac_nxt[i].active = (func_r[i] != AOM_FN_OFF);
			dac_nxt[i].func   = func_r[i];
			// out of range, flagged or switched off all give zero
			dac_nxt[i].code   = (dac_nxt[i].active && inr && !ierr) ? v[15:0] : 16'h0000;
			rng_err_nxt[i]    = dac_nxt[i].active && !inr;
			int_err_nxt[i]    = dac_nxt[i].active && ierr;
		end
	end

	// diagnostic record when the error summary rises from clear while alarms are enabled
	always_comb begin
		err_now     = (|rng_err_r) | (|int_err_r) | perr_r;
		err_sum_nxt = err_now;
		dpend_nxt   = dpend_r;
		diag_nxt    = diag_r;
		if (dpend_r && diag_ready)
			dpend_nxt = 1'b0;
		if (diag_en_r && err_now && !err_sum_r) begin
			dpend_nxt = 1'b1;
			diag_nxt  = {19'h00000, 1'b1, AOM_DIAG_CLASS, perr_r, 3'b000,
				(|rng_err_r) | (|int_err_r), |rng_err_r, 1'b0, |int_err_r};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < AOM_NCH; i++) begin
				out_r[i]  <= 16'h0000;
				func_r[i] <= AOM_FN_RESET;
				dac_r[i]  <= '{active: 1'b1, func: AOM_FN_RESET, code: 16'h0000};
			end
			diag_en_r <= 1'b0;
			perr_r    <= 1'b0;
			aw_hold_r <= 1'b0;
			awaddr_r  <= 8'h00;
			w_hold_r  <= 1'b0;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= AOM_RESP_OKAY;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= AOM_RESP_OKAY;
			rng_err_r <= '0;
			int_err_r <= '0;
			err_sum_r <= 1'b0;
			dpend_r   <= 1'b0;
			diag_r    <= 32'h0000_0000;
		end else if (ce) begin
			for (int i = 0; i < AOM_NCH; i++) begin
				out_r[i]  <= out_nxt[i];
				func_r[i] <= func_nxt[i];
			end
			diag_en_r <= diag_en_nxt;
			perr_r    <= perr_nxt;
			aw_hold_r <= aw_hold_nxt;
			awaddr_r  <= awaddr_nxt;
			w_hold_r  <= w_hold_nxt;
			wdata_r   <= wdata_nxt;
			wstrb_r   <= wstrb_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
			dac_r     <= dac_nxt;
			rng_err_r <= rng_err_nxt;
			int_err_r <= int_err_nxt;
			err_sum_r <= err_sum_nxt;
			dpend_r   <= dpend_nxt;
			diag_r    <= diag_nxt;
		end
	end

	assign dac_o = dac_r;
	always_comb begin
		for (int i = 0; i < AOM_NCH; i++)
			channel_active_leds[i] = dac_r[i].active;
	end
	assign error_summary_led = err_sum_r;
	assign diag_valid        = dpend_r;
	assign diag_data         = diag_r;

	// checks; a frozen clock enable suspends them
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);

	logic fwr0;
	assign fwr0 = do_wr && awaddr_r == AOM_OFS_FUNC && wstrb_r[0];

	chk_keep_func: assert property (
		fwr0 && wdata_r[7:0] == AOM_FN_KEEP |=> func_r[0] == $past(func_r[0]))
		else $error("function 00h changed channel 0");
	chk_off_zero: assert property (
		func_r[1] == AOM_FN_OFF |=> !dac_o[1].active && dac_o[1].code == 16'h0000)
		else $error("switched-off channel still drives");
	chk_tc_full: assert property (
		(func_r[0] == AOM_FN_TC_BI || func_r[0] == AOM_FN_TC_NEG) && out_r[0] == 16'h9400
		|=> dac_o[0].code == 16'h9400)
		else $error("negative full scale not passed");
	chk_tc_under: assert property (
		func_r[0] == AOM_FN_TC_UNI && out_r[0] == 16'hFFFF |=> dac_o[0].code == 16'h0000
		&& rng_err_r[0])
		else $error("underrange code not zeroed");
	chk_range_zero: assert property (
		rng_err_r[2] |-> dac_o[2].code == 16'h0000 ##1 error_summary_led)
		else $error("range error without zero output or lamp");
	chk_bad_func: assert property (
		fwr0 && wdata_r[7:0] == 8'h02 |=> perr_r && func_r[0] == $past(func_r[0]))
		else $error("illegal function number accepted");
	chk_legacy_sign: assert property (
		(func_r[0] == AOM_FN_LG_BI || func_r[0] == AOM_FN_LG_NEG) && out_r[0] == 16'h8080
		|=> dac_o[0].code == 16'hC000)
		else $error("legacy sign or magnitude wrong");
	chk_legacy_ovf: assert property (
		func_r[0] == AOM_FN_LG_BI && out_r[0][AOM_LG_OVF] |=> dac_o[0].code == 16'h0000)
		else $error("legacy overflow flag ignored");
	chk_diag_send: assert property (
		diag_en_r && err_now && !err_sum_r |=> diag_valid && diag_data[11:8] == AOM_DIAG_CLASS)
		else $error("diagnostic record not raised");

endmodule

`default_nettype wire

// *** aom_pkg.sv ***
// constants, types and range table for the four-channel analog output code mapper
package aom_pkg;

	localparam int          AOM_NCH        = 4;
	localparam int          AOM_AW         = 8;

	// register byte offsets
	localparam logic [7:0]  AOM_OFS_OUT0   = 8'h00;
	localparam logic [7:0]  AOM_OFS_OUT1   = 8'h04;
	localparam logic [7:0]  AOM_OFS_OUT2   = 8'h08;
	localparam logic [7:0]  AOM_OFS_OUT3   = 8'h0C;
	localparam logic [7:0]  AOM_OFS_PARAM  = 8'h10;
	localparam logic [7:0]  AOM_OFS_FUNC   = 8'h14;
	localparam logic [7:0]  AOM_OFS_STAT   = 8'h18;
	localparam logic [7:0]  AOM_OFS_DIAG   = 8'h1C;

	// function numbers
	localparam logic [7:0]  AOM_FN_KEEP    = 8'h00;
	localparam logic [7:0]  AOM_FN_OFF     = 8'hFF;
	localparam logic [7:0]  AOM_FN_LG_BI   = 8'h01;
	localparam logic [7:0]  AOM_FN_LG_UNI  = 8'h05;
	localparam logic [7:0]  AOM_FN_LG_MA   = 8'h06;
	localparam logic [7:0]  AOM_FN_LG_NEG  = 8'h07;
	localparam logic [7:0]  AOM_FN_TC_BI   = 8'h09;
	localparam logic [7:0]  AOM_FN_TC_UNI  = 8'h0D;
	localparam logic [7:0]  AOM_FN_TC_MA   = 8'h0E;
	localparam logic [7:0]  AOM_FN_TC_NEG  = 8'h0F;
	localparam logic [7:0]  AOM_FN_RESET   = AOM_FN_TC_BI;

	// accepted code limits, inclusive
	localparam logic signed [16:0] AOM_LG_MAX = 17'sd20480;
	localparam logic signed [16:0] AOM_LG_MIN = -17'sd20480;
	localparam logic signed [16:0] AOM_TC_MAX = 17'sd32511;
	localparam logic signed [16:0] AOM_TC_MIN = -17'sd32512;
	localparam logic signed [16:0] AOM_ZERO   = 17'sd0;

	// legacy word layout
	localparam int          AOM_LG_SIGN    = 7;
	localparam int          AOM_LG_OVF     = 8;
	localparam int          AOM_LG_ERR     = 9;
	localparam int          AOM_LG_ZERO    = 10;

	// parameter, status and diagnostic layout
	localparam int          AOM_DIAG_EN    = 6;
	localparam int          AOM_ST_PERR    = 16;
	localparam int          AOM_ST_DPEND   = 17;
	localparam logic [3:0]  AOM_DIAG_CLASS = 4'h5;
	localparam logic [1:0]  AOM_RESP_OKAY  = 2'b00;
	localparam logic [1:0]  AOM_RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic        active;
		logic [7:0]  func;
		logic [15:0] code;
	} aom_dac_s;

	typedef struct packed {
		logic                bad;
		logic                legacy;
		logic signed [16:0]  lo;
		logic signed [16:0]  hi;
	} aom_range_s;

	function automatic aom_range_s aom_range(input logic [7:0] fn);
		aom_range_s r;
		r = '{bad: 1'b0, legacy: 1'b0, lo: AOM_ZERO, hi: AOM_ZERO};
		unique case (fn)
			AOM_FN_LG_BI:  r = '{1'b0, 1'b1, AOM_LG_MIN, AOM_LG_MAX};
			AOM_FN_LG_UNI: r = '{1'b0, 1'b1, AOM_ZERO, AOM_LG_MAX};
			AOM_FN_LG_MA:  r = '{1'b0, 1'b1, AOM_ZERO, AOM_LG_MAX};
			AOM_FN_LG_NEG: r = '{1'b0, 1'b1, AOM_LG_MIN, AOM_ZERO};
			AOM_FN_TC_BI:  r = '{1'b0, 1'b0, AOM_TC_MIN, AOM_TC_MAX};
			AOM_FN_TC_UNI: r = '{1'b0, 1'b0, AOM_ZERO, AOM_TC_MAX};
			AOM_FN_TC_MA:  r = '{1'b0, 1'b0, AOM_ZERO, AOM_TC_MAX};
			AOM_FN_TC_NEG: r = '{1'b0, 1'b0, AOM_TC_MIN, AOM_ZERO};
			default:       r.bad = 1'b1;
		endcase
		return r;
	endfunction

endpackage

// *** aom_bus_master.sv ***
// backplane bus master model: register bus driver and diagnostic receiver
`timescale 1ns/100ps
`default_nettype none
module aom_bus_master (
	input  wire logic        aclk,
	output var logic [7:0]   awaddr,
	output var logic         awvalid,
	input  wire logic        awready,
	output var logic [31:0]  wdata,
	output var logic [3:0]   wstrb,
	output var logic         wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output var logic         bready,
	output var logic [7:0]   araddr,
	output var logic         arvalid,
	input  wire logic        arready,
	input  wire logic        rvalid,
	output var logic         rready,
	input  wire logic        diag_valid,
	output var logic         diag_ready,
	input  wire logic [31:0] diag_data
);
	logic        slow;
	logic [31:0] diag_last;
	int          diag_cnt;
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = '0;
		bready = 1'b1;
		rready = 1'b1;
		diag_ready = 1'b0;
		slow = 1'b0;
		diag_cnt = 0;
		diag_last = '0;
	end
	// slow mode takes a record only every other cycle
	always @(posedge aclk) begin
		if (diag_valid && diag_ready) begin
			diag_last <= diag_data;
			diag_cnt <= diag_cnt + 1;
		end
		diag_ready <= slow ? !diag_ready : 1'b1;
	end
	// one word per channel, lane 1 the high byte; one function byte per lane
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] resp);
		logic aw_t;
		logic w_t;
		aw_t = 1'b0;
		w_t = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_t && w_t)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_t = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_t = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		resp = bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
	endtask
endmodule
`default_nettype wire

// *** analog_out_code_mapper_test.sv ***
// self-checking bench for the analog output code mapper
`timescale 1ns/100ps
`default_nettype none
module analog_out_code_mapper_test;
	import aom_pkg::*;
	logic                       aclk = 1'b0;
	logic                       aresetn = 1'b0;
	logic                       ce = 1'b1;
	logic [7:0]                 awaddr, araddr;
	logic                       awvalid, awready, wvalid, wready, bvalid, bready;
	logic                       arvalid, arready, rvalid, rready, diag_valid, diag_ready;
	logic [31:0]                wdata, rdata, diag_data;
	logic [3:0]                 wstrb, channel_active_leds;
	logic [1:0]                 bresp, rresp;
	logic                       error_summary_led;
	aom_dac_s [AOM_NCH-1:0]     dac_o;
	logic [33:0]                rd_q[$];
	logic [15:0]                lfsr_r = 16'h000B;
	logic [15:0]                rw[4];
	int                         mismatches = 0;
	int                         n_tests = 0;
	// fn, word, expected code, error lamp (2 = not judged)
	logic [47:0] tbl[22] = '{48'h097EFF7EFF00, 48'h098100810000, 48'h0980FF000001,
		48'h097F00000001, 48'h0D6C006C0000, 48'h0DFFFF000001, 48'h0E3600360000,
		48'h0E7F00000001, 48'h0F9400940000, 48'h0FCA00CA0000, 48'h0F0001000001,
		48'h01A000500000, 48'h01A080B00000, 48'h01A008000001, 48'h058000400000,
		48'h050880000001, 48'h064000200000, 48'h078080C00000, 48'h070800000001,
		48'h018100000001, 48'h018200000001, 48'h018400400000};

	always #5 aclk = ~aclk;

	aom_mapper DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .dac_o(dac_o), .channel_active_leds(channel_active_leds),
		.error_summary_led(error_summary_led), .diag_valid(diag_valid),
		.diag_ready(diag_ready), .diag_data(diag_data));

	aom_bus_master u_mst (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
		.rready(rready), .diag_valid(diag_valid), .diag_ready(diag_ready),
		.diag_data(diag_data));

	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic [15:0] tc_exp(input logic [15:0] v);
		return (($signed(v) < -32512) || ($signed(v) > 32511)) ? 16'h0000 : v;
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic [1:0] resp;
		u_mst.wr(a, d, s, resp);
		check(resp, er);
	endtask
	task automatic r(input logic [7:0] a, input logic [33:0] exp);
		rd_q.push_back(exp);
		u_mst.rd(a);
	endtask
	task automatic summarize();
		$display("mismatches %0d, comparisons %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// read results are judged as they come back, oldest note first
	always @(posedge aclk) begin
		if (rvalid && rready)
			check({rresp, rdata}, rd_q.pop_front());
	end

	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		summarize();
	end

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int c = 0; c < 4; c++) check(dac_o[c], {1'b1, 8'h09, 16'h0000});
		check({channel_active_leds, error_summary_led}, 5'b11110);
		r(AOM_OFS_FUNC, {2'b00, 32'h09090909});
		for (int i = 0; i < 22; i++) begin
			w(AOM_OFS_FUNC, {4{tbl[i][47:40]}}, 4'h1, AOM_RESP_OKAY);
			w(AOM_OFS_OUT0, {16'hFFFF, tbl[i][39:24]}, 4'hF, AOM_RESP_OKAY);
			repeat (2) @(posedge aclk);
			check(dac_o[0], {1'b1, tbl[i][47:40], tbl[i][23:8]});
			if (tbl[i][1:0] != 2'd2) check(error_summary_led, tbl[i][0]);
		end
		r(AOM_OFS_OUT0, {2'b00, 32'h00008000});
		check(u_mst.diag_cnt, 0);
		w(AOM_OFS_FUNC, 32'h0942FF00, 4'hF, AOM_RESP_OKAY);
		repeat (2) @(posedge aclk);
		check(channel_active_leds, 4'b1101);
		check(dac_o[1].active, 1'b0);
		check(dac_o[0].func, 8'h01);
		check(dac_o[2].func, 8'h09);
		check(error_summary_led, 1'b1);
		r(AOM_OFS_STAT, {2'b00, 32'h0001000D});
		w(AOM_OFS_FUNC, 32'h00000002, 4'h1, AOM_RESP_OKAY);
		// sticky error is cleared by writing one to it
		w(AOM_OFS_STAT, 32'h00010000, 4'h4, AOM_RESP_OKAY);
		r(AOM_OFS_STAT, {2'b00, 32'h0000000D});
		check(dac_o[0].func, 8'h01);
		w(AOM_OFS_FUNC, 32'h09090909, 4'hF, AOM_RESP_OKAY);
		for (int k = 0; k < 4; k++) begin
			for (int c = 0; c < 4; c++) begin
				lfsr_r = lfsr_next(lfsr_r);
				rw[c] = lfsr_r;
				w(8'(4 * c), {16'h0000, rw[c]}, 4'hF, AOM_RESP_OKAY);
			end
			repeat (2) @(posedge aclk);
			for (int c = 0; c < 4; c++) check(dac_o[c].code, tc_exp(rw[c]));
		end
		w(AOM_OFS_OUT0, 32'h00000000, 4'hF, AOM_RESP_OKAY);
		w(AOM_OFS_OUT1, 32'h00000000, 4'hF, AOM_RESP_OKAY);
		w(AOM_OFS_OUT2, 32'h00000000, 4'hF, AOM_RESP_OKAY);
		w(AOM_OFS_OUT3, 32'h00000000, 4'hF, AOM_RESP_OKAY);
		u_mst.slow <= 1'b1;
		w(AOM_OFS_PARAM, 32'h00000040, 4'h1, AOM_RESP_OKAY);
		w(AOM_OFS_OUT2, 32'h000080FF, 4'hF, AOM_RESP_OKAY);
		for (int k = 0; k < 50 && u_mst.diag_cnt == 0; k++) @(posedge aclk);
		check(u_mst.diag_cnt, 1);
		check({u_mst.diag_last[31:8], u_mst.diag_last[2]}, {24'h000015, 1'b1});
		w(8'h20, 32'h00001234, 4'hF, AOM_RESP_SLVERR);
		r(8'h20, {AOM_RESP_SLVERR, 32'h00000000});
		ce <= 1'b0;
		repeat (2) @(posedge aclk);
		check({awready, wready, arready}, 3'b000);
		ce <= 1'b1;
		repeat (2) @(posedge aclk);
		summarize();
	end
endmodule
`default_nettype wire
